/* File: ccfs_defines.svh */
// Constants for the core clock and fetch strobe block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CCFS_DEFINES_SVH
`define CCFS_DEFINES_SVH

// Number of phase slots in one machine cycle
`define CCFS_PHASES 3'h6
// Last phase slot index
`define CCFS_PHASE_LAST 3'h5
// Address latch strobe slots
`define CCFS_ALE_SLOT_A 3'h0
`define CCFS_ALE_SLOT_B 3'h3
// Program read strobe slots
`define CCFS_READ_SLOT_A 3'h1
`define CCFS_READ_SLOT_B 3'h4
// Top of internal program memory, small and large variant
`define CCFS_ROM_TOP_SMALL 16'h3fff
`define CCFS_ROM_TOP_LARGE 16'h7fff
// Fetch start address with external fetch forced
`define CCFS_RESET_PC 16'h0000
// Reset values
`define CCFS_RST_MODE 1'h0
`define CCFS_RST_PIN 1'h1
// Cycles of synchroniser delay before the strap is valid
`define CCFS_STRAP_WAIT 2'h2

`endif

/* File: ccfs_pkg.sv */
// Types for the core clock and fetch strobe block.
// Assumes the defines header sits in the same folder.
`include "ccfs_defines.svh"

package ccfs_pkg;

    // Clock mode of the core
    typedef enum logic
    {
        CCFS_STANDARD_CLOCK_MODE,
        CCFS_DOUBLE_SPEED_MODE
    } ccfs_mode_t;

    // Strobes to the external program memory and latch
    typedef struct packed
    {
        logic address_latch_strobe;
        logic program_read_strobe_b;
    } ccfs_strobes_t;

    // Timing handed to the core
    typedef struct packed
    {
        logic phase_tick;
        logic cycle_start;
        logic [2:0] phase;
    } ccfs_timing_t;

endpackage

/* File: ccfs_top.sv */
// Core clock generator and external program memory strobes.
// Assumes a core on clk_sys that reports its program counter, idle state
// and external data accesses; crystal and fetch pins come from outside.
//
// Notes on behaviour
// R1: Latch strobe at osc/6, or osc/3 doubled.
// R2: Skip one latch strobe per data access.
// R3: Latch disable bit mutes strobe on internal fetch.
// R4: Program read strobe twice per machine cycle externally.
// R5: Skip two read strobes per data access.
// R6: No read strobe on internal fetches.
// R7: Fetch select low forces external fetch from zero.
// R8: Fetch select high: external only above memory top.
// R9: Security level one latches fetch select at reset.
// R10: Double speed: six oscillator periods per machine cycle.
// R11: Standard mode divides crystal by two; double bypasses.
// R12: Software bit switches divider at run time.
// R13: Mode bit sampled on divided clock rising edge.
// R14: Idle holds both strobes high.
// R15: Mode bit resets to standard clocking.
`timescale 1ns/1ps
`include "ccfs_defines.svh"

module ccfs_top #(
    parameter logic [15:0] ROM_TOP = `CCFS_ROM_TOP_LARGE
) (
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // Pins from outside
    input wire logic crystal_input,
    input wire logic external_fetch_select_b,
    // Control from the core and its registers
    input wire logic double_speed_mode,
    input wire logic latch_disable,
    input wire logic security_level1,
    input wire logic idle_mode,
    input wire logic xdata_access,
    input wire logic [15:0] program_counter,
    // Strobes to the external memory
    output ccfs_pkg::ccfs_strobes_t strobes,
    // Timing and status to the core
    output ccfs_pkg::ccfs_timing_t timing,
    output ccfs_pkg::ccfs_mode_t mode,
    output logic fetch_external
);
    import ccfs_pkg::*;

    // Crystal synchroniser stages
    logic xtal_s1_q;
    logic xtal_s2_q;
    // Previous synchronised crystal level
    logic xtal_prev_q;
    // Fetch select synchroniser stages
    logic fsel_s1_q;
    logic fsel_s2_q;
    // Divide-by-two stage
    logic div_q;
    // Sampled clock mode
    ccfs_mode_t mode_q;
    // Phase slot within the machine cycle
    logic [2:0] phase_q;
    logic [2:0] phase_d;
    // Data access flag held for the current machine cycle
    logic xdata_q;
    // Strap capture
    logic [1:0] strap_cnt_q;
    logic strap_done_q;
    logic fsel_latched_q;
    // Strobe registers
    logic ale_q;
    logic rd_b_q;
    logic ale_d;
    logic rd_b_d;
    // Timing registers
    logic tick_q;
    logic start_q;
    // Fetch source register
    logic fetch_ext_q;
    logic fetch_ext_d;
    // Combinational events
    logic osc_tick;
    logic div_rise;
    logic phase_tick;
    logic fsel_eff;

    // Two flip-flops on the crystal pin, then an edge memory
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            xtal_s1_q <= 1'h0;
            xtal_s2_q <= 1'h0;
            xtal_prev_q <= 1'h0;
        end
        else if (clk_en)
        begin
            xtal_s1_q <= crystal_input;
            xtal_s2_q <= xtal_s1_q;
            xtal_prev_q <= xtal_s2_q;
        end
    end

    // One oscillator period per crystal rising edge
    assign osc_tick = xtal_s2_q & ~xtal_prev_q;
    // Divided clock goes high on this oscillator period
    assign div_rise = osc_tick & ~div_q;

    // Divide-by-two stage runs in both modes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            div_q <= 1'h0;
        end
        else if (clk_en && osc_tick)
        begin
            div_q <= ~div_q;
        end
    end

    // Mode bit taken only on the divided rising edge, so no glitch
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            mode_q <= ccfs_mode_t'(`CCFS_RST_MODE); // R15
        end
        else if (clk_en && div_rise)
        begin
            // Software switches the divider at run time
            mode_q <= double_speed_mode ? CCFS_DOUBLE_SPEED_MODE
                                        : CCFS_STANDARD_CLOCK_MODE; // R12 R13
        end
    end

    // Phase clock: every second oscillator period, or every one doubled
    always_comb
    begin
        if (mode_q == CCFS_DOUBLE_SPEED_MODE)
        begin
            phase_tick = osc_tick; // R10 R11
        end
        else
        begin
            phase_tick = div_rise; // R11
        end
    end

    // Six phase slots make one machine cycle
    always_comb
    begin
        if (phase_q == `CCFS_PHASE_LAST)
        begin
            phase_d = 3'h0;
        end
        else
        begin
            phase_d = phase_q + 3'h1;
        end
    end

    // Phase slot counter
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            phase_q <= `CCFS_PHASE_LAST;
        end
        else if (clk_en && phase_tick)
        begin
            phase_q <= phase_d; // R1 R10
        end
    end

    // Data access flag latched at the start of each machine cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            xdata_q <= 1'h0;
        end
        else if (clk_en && phase_tick && phase_d == 3'h0)
        begin
            xdata_q <= xdata_access;
        end
    end

    // Two flip-flops on the fetch select pin
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            fsel_s1_q <= `CCFS_RST_PIN;
            fsel_s2_q <= `CCFS_RST_PIN;
        end
        else if (clk_en)
        begin
            fsel_s1_q <= external_fetch_select_b;
            fsel_s2_q <= fsel_s1_q;
        end
    end

    // Strap capture once the synchroniser holds the pin, after release
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'h0;
            fsel_latched_q <= `CCFS_RST_PIN;
        end
        else if (clk_en && !strap_done_q)
        begin
            if (strap_cnt_q == `CCFS_STRAP_WAIT)
            begin
                // Held for good until the next reset
                fsel_latched_q <= fsel_s2_q; // R9
                strap_done_q <= 1'h1;
            end
            else
            begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
        end
    end

    // Secured parts ignore later pin changes
    always_comb
    begin
        if (security_level1)
        begin
            fsel_eff = fsel_latched_q; // R9
        end
        else
        begin
            fsel_eff = fsel_s2_q;
        end
    end

    // Fetch source from pin and program counter
    always_comb
    begin
        if (!fsel_eff)
        begin
            // Pin low: all code external, starting at zero
            fetch_ext_d = 1'h1; // R7
        end
        else
        begin
            // Pin high: external only above the internal top
            fetch_ext_d = (program_counter > ROM_TOP); // R8
        end
    end

    // Fetch source register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            fetch_ext_q <= 1'h0;
        end
        else if (clk_en)
        begin
            fetch_ext_q <= fetch_ext_d;
        end
    end

    // Strobe levels for the coming phase slot
    always_comb
    begin
        ale_d = 1'h0;
        rd_b_d = 1'h1;
        if (idle_mode)
        begin
            // Both strobes parked high in idle
            ale_d = 1'h1; // R14
            rd_b_d = 1'h1; // R14
        end
        else
        begin
            // Latch strobe twice per machine cycle
            if (phase_d == `CCFS_ALE_SLOT_A || phase_d == `CCFS_ALE_SLOT_B)
            begin
                ale_d = 1'h1; // R1
            end
            // First strobe of a data access cycle is dropped
            // Slot 0 opens the new cycle, so its flag is the one being latched now
            if (phase_d == `CCFS_ALE_SLOT_A && xdata_access)
            begin
                ale_d = 1'h0; // R2
            end
            // Optional mute while fetching internally
            if (latch_disable && !fetch_ext_q)
            begin
                ale_d = 1'h0; // R3
            end
            // Read strobe twice per cycle, only for external fetch
            if (fetch_ext_q && !xdata_q &&
                (phase_d == `CCFS_READ_SLOT_A || phase_d == `CCFS_READ_SLOT_B))
            begin
                rd_b_d = 1'h0; // R4 R5 R6
            end
        end
    end

    // Strobe registers move on each phase slot; idle acts at once
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ale_q <= 1'h0;
            rd_b_q <= 1'h1;
        end
        else if (clk_en && (phase_tick || idle_mode))
        begin
            ale_q <= ale_d;
            rd_b_q <= rd_b_d;
        end
    end

    // Timing pulses to the core, one cycle each
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            tick_q <= 1'h0;
            start_q <= 1'h0;
        end
        else if (clk_en)
        begin
            tick_q <= phase_tick;
            start_q <= phase_tick && (phase_d == 3'h0);
        end
    end

    // Outputs
    assign strobes.address_latch_strobe = ale_q;
    assign strobes.program_read_strobe_b = rd_b_q;
    assign timing.phase_tick = tick_q;
    assign timing.cycle_start = start_q;
    assign timing.phase = phase_q;
    assign mode = mode_q;
    assign fetch_external = fetch_ext_q;

endmodule

/* File: ccfs_assertions.sv */
// Port checker for ccfs_top.
// Assumes binding into ccfs_top and clk_en high while in reset.
`timescale 1ns/1ps
module ccfs_assertions
import ccfs_pkg::*;
#(parameter logic [15:0] ROM_TOP = 16'h7fff)
(
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // Pins and core inputs
    input wire logic external_fetch_select_b,
    input wire logic security_level1,
    input wire logic idle_mode,
    input wire logic [15:0] program_counter,
    // Outputs watched
    input ccfs_pkg::ccfs_strobes_t strobes,
    input ccfs_pkg::ccfs_timing_t timing,
    input ccfs_pkg::ccfs_mode_t mode,
    input wire logic fetch_external
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    idle_strobes_a: assert property (idle_mode && clk_en |=> strobes == 2'b11)
        else $error("strobes not high in idle");
    read_slot_a: assert property ($fell(strobes.program_read_strobe_b) |-> timing.phase inside {3'h1, 3'h4})
        else $error("read strobe outside its slots");
    read_internal_a: assert property ($fell(strobes.program_read_strobe_b) |-> $past(fetch_external))
        else $error("read strobe on internal fetch");
    latch_slot_a: assert property ($rose(strobes.address_latch_strobe) && !$past(idle_mode)
        |-> timing.phase inside {3'h0, 3'h3})
        else $error("latch strobe outside its slots");
    phase_step_a: assert property ($changed(timing.phase)
        |-> timing.phase == ($past(timing.phase) == 3'h5 ? 3'h0 : $past(timing.phase) + 3'h1))
        else $error("phase skipped a slot");
    cycle_start_a: assert property (timing.cycle_start |-> timing.phase_tick && timing.phase == 3'h0)
        else $error("cycle start away from slot zero");
    tick_phase_a: assert property (timing.phase_tick |-> $changed(timing.phase))
        else $error("phase tick without phase step");
    mode_reset_a: assert property ($rose(rst_b) |-> mode == CCFS_STANDARD_CLOCK_MODE)
        else $error("mode not standard after reset");
    high_fetch_a: assert property ((clk_en && program_counter > ROM_TOP)[*4] |-> fetch_external)
        else $error("no external fetch above memory top");
    internal_fetch_a: assert property ((clk_en && !security_level1 && external_fetch_select_b
        && program_counter <= ROM_TOP)[*6] |-> !fetch_external)
        else $error("external fetch inside memory");

    // Main scenarios reached
    cover property (idle_mode ##1 idle_mode);
    cover property ($fell(strobes.program_read_strobe_b));
    cover property (mode == CCFS_DOUBLE_SPEED_MODE);
endmodule

bind ccfs_top ccfs_assertions #(.ROM_TOP(ROM_TOP)) chk (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .external_fetch_select_b(external_fetch_select_b), .security_level1(security_level1),
    .idle_mode(idle_mode), .program_counter(program_counter), .strobes(strobes), .timing(timing),
    .mode(mode), .fetch_external(fetch_external));

/* File: ccfs_ext_memory.sv */
// External program memory with address latch, behavioural.
// Assumes the strobes and program counter of ccfs_top.
`timescale 1ns/1ps
module ccfs_ext_memory
import ccfs_pkg::*;
(
    // Bench clock
    input wire logic clk_sys,
    // From the device
    input ccfs_pkg::ccfs_strobes_t strobes,
    input wire logic [15:0] program_counter,
    // Counts of latches and reads
    output int latches,
    output int reads
);
    logic ale_q = 1'b0;
    logic rd_q = 1'b1;
    logic [15:0] addr_q = 16'h0000;
    initial
    begin
        latches = 0;
        reads = 0;
    end
    // Latch address as latch strobe falls, count reads as read strobe falls
    always @(negedge clk_sys)
    begin
        if (ale_q && !strobes.address_latch_strobe)
        begin
            addr_q <= program_counter;
            latches <= latches + 1;
        end
        if (rd_q && !strobes.program_read_strobe_b)
            reads <= reads + 1;
        ale_q <= strobes.address_latch_strobe;
        rd_q <= strobes.program_read_strobe_b;
    end
endmodule

/* File: ccfs_top_tb_top.sv */
// Self-checking bench for ccfs_top.
// Assumes the checker and the memory model are compiled first.
`timescale 1ns/1ps
module ccfs_top_tb_top;
    import ccfs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic crystal_input = 1'b0;
    logic external_fetch_select_b = 1'b1;
    logic double_speed_mode = 1'b0;
    logic latch_disable = 1'b0;
    logic security_level1 = 1'b0;
    logic idle_mode = 1'b0;
    logic xdata_access = 1'b0;
    logic [15:0] program_counter = 16'h0000;
    ccfs_strobes_t strobes;
    ccfs_timing_t timing;
    ccfs_mode_t mode;
    logic fetch_external;
    logic xtal_q = 1'b0;
    int latches, reads, osc_k, lat_k, rd_k;
    int n_fail = 0;
    int checks_done = 0;
    int osc_n = 0;
    int osc_c = 0;
    int lat_c = 0;
    int rd_c = 0;

    always #4 clk_sys = ~clk_sys;
    // Oscillator of six system clocks per period, edges just after a rising clock edge
    initial
    begin
        #5;
        forever #24 crystal_input = ~crystal_input;
    end

    ccfs_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .crystal_input(crystal_input),
        .external_fetch_select_b(external_fetch_select_b), .double_speed_mode(double_speed_mode),
        .latch_disable(latch_disable), .security_level1(security_level1), .idle_mode(idle_mode),
        .xdata_access(xdata_access), .program_counter(program_counter), .strobes(strobes),
        .timing(timing), .mode(mode), .fetch_external(fetch_external));
    ccfs_ext_memory mem (.clk_sys(clk_sys), .strobes(strobes), .program_counter(program_counter),
        .latches(latches), .reads(reads));

    // Counts of one whole machine cycle, taken at each cycle start
    always @(negedge clk_sys)
    begin
        xtal_q <= crystal_input;
        osc_n <= osc_n + int'(crystal_input && !xtal_q);
        if (timing.cycle_start === 1'b1)
        begin
            osc_k <= osc_n - osc_c;
            lat_k <= latches - lat_c;
            rd_k <= reads - rd_c;
            osc_c <= osc_n;
            lat_c <= latches;
            rd_c <= reads;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge timing.cycle_start);
        @(negedge clk_sys);
        #1;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        void'($urandom(8));
        repeat (8) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        check(mode, CCFS_STANDARD_CLOCK_MODE);
        // Every mode, fetch source, data access and latch mute
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_sys);
            #1;
            double_speed_mode = i[0];
            xdata_access = i[2];
            latch_disable = i[3];
            external_fetch_select_b = !(i[1] && i[3]);
            program_counter = (i[1] && !i[3]) ? 16'h8000 : (i[1] ? 16'($urandom) : 16'h7fff);
            cycles(4);
            check(mode, i[0]);
            check(osc_k, i[0] ? 6 : 12);
            check(fetch_external, i[1]);
            check(lat_k, (i[3] && !i[1]) ? 0 : (i[2] ? 1 : 2));
            check(rd_k, (i[1] && !i[2]) ? 2 : 0);
            $display("case %0d done", i);
        end
        idle_mode = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check(strobes, 2'b11);
        idle_mode = 1'b0;
        $display("idle done");
        // Strap taken at reset, pin change afterwards ignored
        security_level1 = 1'b1;
        external_fetch_select_b = 1'b0;
        program_counter = 16'h0000;
        rst_b = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        cycles(2);
        check(fetch_external, 1'b1);
        external_fetch_select_b = 1'b1;
        cycles(2);
        check(fetch_external, 1'b1);
        $display("strap done");
        results();
    end

    // Hang guard
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
endmodule
